// ---- common/dma_pkg.sv ----
// Purpose: shared constants and types of the master DMA launcher
// Assumes: 32-bit local data path, register window of 1 KByte
// Notes: transaction control codes and bus commands are decoded here
`default_nettype none
package dma_pkg;
  localparam int DATA_W = 32;
  localparam int WIN_ADDR_W = 10;
  localparam int RAM_BYTES = 1024;
  localparam int RAM_WORDS = RAM_BYTES / (DATA_W / 8);
  localparam int RAM_ADDR_W = $clog2(RAM_WORDS);
  localparam int COUNT_W = 8;
  localparam int FIFO_DEPTH = 32;
  localparam logic [WIN_ADDR_W-1:0] SYS_ADDR_OFFSET = 10'h004;
  localparam logic [WIN_ADDR_W-1:0] DESC_OFFSET = 10'h008;
  localparam logic [DATA_W-1:0] SYS_ADDR_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] IO_REG_RESET = 32'h0000_0000;
  // transaction control codes
  localparam logic [3:0] CTRL_MEM_RD32 = 4'h0;
  localparam logic [3:0] CTRL_MEM_RD64 = 4'h2;
  localparam logic [3:0] CTRL_IO_RD = 4'h4;
  localparam logic [3:0] CTRL_IO_WR = 4'h6;
  localparam logic [3:0] CTRL_MEM_WR32 = 4'h8;
  localparam logic [3:0] CTRL_MEM_WR64 = 4'hA;
  // bus commands driven with the address
  localparam logic [3:0] CMD_IO_READ = 4'h2;
  localparam logic [3:0] CMD_IO_WRITE = 4'h3;
  localparam logic [3:0] CMD_MEM_READ = 4'h6;
  localparam logic [3:0] CMD_MEM_WRITE = 4'h7;

  typedef struct packed {
    logic [3:0] ctrl;
    logic [11:0] reserved;
    logic [COUNT_W-1:0] count;
    logic [RAM_ADDR_W-1:0] localAddr;
  } desc_t;
  localparam desc_t DESC_RESET = 32'h0000_0000;

  typedef struct packed {
    logic write;
    logic read;
    logic [WIN_ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } reg_access_t;

  typedef struct packed {
    logic write;
    logic [RAM_ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } ram_port_t;

  typedef struct packed {
    logic req;
    logic [3:0] cmd;
    logic [DATA_W-1:0] addr;
    logic wide;
  } master_req_t;

  typedef struct packed {
    logic known;
    logic isIo;
    logic isWrite;
    logic wide;
    logic [3:0] cmd;
  } decode_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_REQ = 4'h2,
    ST_WRITE = 4'h4,
    ST_READ = 4'h8
  } dma_state_t;

  function automatic decode_t decodeCtrl(input logic [3:0] ctrl);
    decode_t d;
    d = '0;
    d.known = 1'b1;
    case (ctrl)
      CTRL_MEM_RD32: d.cmd = CMD_MEM_READ;
      CTRL_MEM_RD64: begin
        d.cmd = CMD_MEM_READ;
        d.wide = 1'b1;
      end
      CTRL_IO_RD: begin
        d.cmd = CMD_IO_READ;
        d.isIo = 1'b1;
      end
      CTRL_IO_WR: begin
        d.cmd = CMD_IO_WRITE;
        d.isIo = 1'b1;
        d.isWrite = 1'b1;
      end
      CTRL_MEM_WR32: begin
        d.cmd = CMD_MEM_WRITE;
        d.isWrite = 1'b1;
      end
      CTRL_MEM_WR64: begin
        d.cmd = CMD_MEM_WRITE;
        d.isWrite = 1'b1;
        d.wide = 1'b1;
      end
      default: d.known = 1'b0;
    endcase
    return d;
  endfunction
endpackage
`default_nettype wire

// ---- dv/pci_master_dma_launcher_tb.sv ----
// Purpose: self-checking bench of the DMA launcher
// Assumes: partner answers every request; seed fixed
// Notes: registers and RAM reached only through their own ports
`default_nettype none
module pci_master_dma_launcher_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import dma_pkg::*;
  logic core_clk, srst, slow, masterGrant, transactionEnd, txValid;
  logic txReady, rxValid, master_end_request_n, busy;
  reg_access_t regAccess;
  ram_port_t targetRam;
  master_req_t masterReq;
  logic [DATA_W-1:0] regReadData, targetRamReadData, txData, rxData;
  logic [DATA_W-1:0] rxBase, got, d, ioVal, seed;
  logic [DATA_W-1:0] ram [256];
  logic [3:0] codes [6];
  int failures, check_count, i, j;

  pci_master_dma_launcher #(.FIFO_WORDS(FIFO_DEPTH)) dut (
    .core_clk(core_clk), .srst(srst), .ce(1'b1), .regAccess(regAccess),
    .regReadData(regReadData), .targetRam(targetRam),
    .targetRamReadData(targetRamReadData), .masterReq(masterReq),
    .masterGrant(masterGrant), .transactionEnd(transactionEnd),
    .txData(txData), .txValid(txValid), .txReady(txReady),
    .rxData(rxData), .rxValid(rxValid),
    .master_end_request_n(master_end_request_n), .busy(busy));

  pci_target_model model (
    .core_clk(core_clk), .srst(srst), .slow(slow), .rxBase(rxBase),
    .masterReq(masterReq), .masterGrant(masterGrant),
    .transactionEnd(transactionEnd), .txData(txData), .txValid(txValid),
    .txReady(txReady), .rxData(rxData), .rxValid(rxValid),
    .master_end_request_n(master_end_request_n));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [3:0] expCmd(input logic [3:0] c);
    if (c == 4'h4) return 4'h2;
    if (c == 4'h6) return 4'h3;
    return c[3] ? 4'h7 : 4'h6;
  endfunction

  task automatic print_verdict();
    if (failures == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chkWord(input string nm, input logic [31:0] e,
                         input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chkFlag(input string nm, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %b seen %b", nm, e, g);
    end
  endtask

  // hold keeps the strobe up so a second write lands on the next edge
  task automatic regWr(input logic [9:0] a, input logic [31:0] v,
                       input logic hold);
    regAccess = '{1'b1, 1'b0, a, v};
    @(posedge core_clk);
    #1;
    if (!hold) begin
      regAccess = '0;
      @(posedge core_clk);
      #1;
    end
  endtask

  task automatic regRd(input logic [9:0] a, output logic [31:0] v);
    regAccess = '{1'b0, 1'b1, a, 32'h0000_0000};
    @(posedge core_clk);
    #1 regAccess = '0;
    v = regReadData;
    @(posedge core_clk);
    #1;
  endtask

  task automatic ramWr(input logic [7:0] a, input logic [31:0] v);
    targetRam = '{1'b1, a, v};
    @(posedge core_clk);
    #1 targetRam.write = 1'b0;
    @(posedge core_clk);
    #1;
  endtask

  task automatic ramRd(input logic [7:0] a, output logic [31:0] v);
    targetRam = '{1'b0, a, 32'h0000_0000};
    @(posedge core_clk);
    #1 v = targetRamReadData;
  endtask

  task automatic waitIdle();
    for (j = 0; j < 400 && busy !== 1'b0; j++) @(negedge core_clk);
    if (j == 400) begin
      failures++;
      print_verdict();
    end
    @(posedge core_clk);
    #1;
  endtask

  task automatic runXfer(input logic [3:0] c, input logic [7:0] n,
                         input logic [7:0] la);
    logic [31:0] sa;
    logic io;
    logic wr;
    int words;
    sa = rnd();
    io = c == 4'h4 || c == 4'h6;
    wr = c[3] || c == 4'h6;
    words = io ? 1 : int'(n);
    rxBase = rnd();
    model.txq.delete();
    for (i = 0; i < words; i++) begin
      ram[la + 8'(i)] = rnd();
      ramWr(la + 8'(i), ram[la + 8'(i)]);
    end
    regWr(SYS_ADDR_OFFSET, sa, 1'b1);
    regWr(DESC_OFFSET, {c, 12'h000, n, la}, 1'b0);
    chkFlag("busy", 1'b1, busy);
    chkFlag("req", 1'b1, masterReq.req);
    chkWord("cmd", 32'(expCmd(c)), 32'(masterReq.cmd));
    chkWord("addr", sa, masterReq.addr);
    chkFlag("wide", c == 4'h2 || c == 4'hA, masterReq.wide);
    waitIdle();
    if (wr) begin
      chkWord("txCount", 32'(words), 32'(model.txq.size()));
      for (i = 0; i < words && i < model.txq.size(); i++) begin
        chkWord("txWord", io ? ioVal : ram[la + 8'(i)], model.txq[i]);
      end
    end else if (io) begin
      ioVal = rxBase;
    end else begin
      for (i = 0; i < words; i++) begin
        ramRd(la + 8'(i), got);
        chkWord("ramWord", rxBase + 32'(i), got);
        ram[la + 8'(i)] = got;
      end
    end
  endtask

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  initial begin
    seed = 32'h0001_50AD;
    failures = 0;
    check_count = 0;
    srst = 1'b1;
    slow = 1'b0;
    rxBase = '0;
    regAccess = '0;
    targetRam = '0;
    ioVal = IO_REG_RESET;
    codes = '{4'h6, 4'h4, 4'h0, 4'h2, 4'h8, 4'hA};
    repeat (10) @(posedge core_clk);
    #1 srst = 1'b0;
    chkFlag("busy", 1'b0, busy);
    chkFlag("endReq", 1'b1, master_end_request_n);
    regRd(SYS_ADDR_OFFSET, got);
    chkWord("sysAddr", SYS_ADDR_RESET, got);
    regRd(DESC_OFFSET, got);
    chkWord("desc", 32'(DESC_RESET), got);
    d = rnd();
    regWr(SYS_ADDR_OFFSET, d, 1'b0);
    regRd(SYS_ADDR_OFFSET, got);
    chkWord("sysAddr", d, got);
    d = rnd();
    d[31:28] = 4'hF;
    regWr(DESC_OFFSET, d, 1'b0);
    chkFlag("busy", 1'b0, busy);
    regRd(DESC_OFFSET, got);
    chkWord("desc", {d[31:28], 12'h000, d[15:0]}, got);
    regRd(10'h00C, got);
    chkWord("unmapped", 32'h0000_0000, got);
    for (int c = 0; c < 6; c++) begin
      slow = c[0];
      runXfer(codes[c], 8'(rnd() % 8 + 1), 8'(rnd()));
    end
    // count zero on an I/O write: the word of the last I/O read goes out
    runXfer(4'h6, 8'h00, 8'h00);
    runXfer(4'hA, 8'h04, 8'hFE);
    runXfer(4'h2, 8'h03, 8'hFF);
    for (int c = 0; c < 8; c++) begin
      slow = 1'(rnd() % 2);
      runXfer(codes[rnd() % 6], 8'(rnd() % 8 + 1), 8'(rnd()));
    end
    model.txq.delete();
    regWr(SYS_ADDR_OFFSET, rnd(), 1'b1);
    regWr(DESC_OFFSET, {4'h8, 12'h000, 8'h03, 8'h10}, 1'b0);
    regWr(DESC_OFFSET, {4'h4, 12'h000, 8'h01, 8'h20}, 1'b0);
    waitIdle();
    repeat (5) @(posedge core_clk);
    #1 chkFlag("busy", 1'b0, busy);
    chkWord("txCount", 32'h0000_0003, 32'(model.txq.size()));
    regWr(DESC_OFFSET, {4'h8, 12'h000, 8'h00, 8'h30}, 1'b0);
    chkFlag("busy", 1'b0, busy);
    print_verdict();
  end
endmodule
`default_nettype wire

// ---- dv/pci_target_model.sv ----
// Purpose: far-side bus target seen by the DMA launcher
// Assumes: grant follows a request one cycle later; slow inserts wait cycles
// Notes: ends a transfer after the beat flagged as last, or after 300 cycles without it
`default_nettype none
module pci_target_model (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic slow,
  input wire logic [dma_pkg::DATA_W-1:0] rxBase,
  input wire dma_pkg::master_req_t masterReq,
  output logic masterGrant,
  output logic transactionEnd,
  input wire logic [dma_pkg::DATA_W-1:0] txData,
  input wire logic txValid,
  output logic txReady,
  output logic [dma_pkg::DATA_W-1:0] rxData,
  output logic rxValid,
  input wire logic master_end_request_n
);
  timeunit 1ns;
  timeprecision 1ps;
  import dma_pkg::*;
  logic [DATA_W-1:0] txq[$];
  logic last;
  logic wr;
  int n;
  int k;
  initial begin
    masterGrant = 1'b0;
    transactionEnd = 1'b0;
    txReady = 1'b0;
    rxValid = 1'b0;
    rxData = 32'hFFFF_FFFF;
    forever begin
      // sampled mid-cycle so the request edge is never raced
      @(negedge core_clk);
      if (!srst && masterReq.req) begin
        wr = masterReq.cmd == CMD_MEM_WRITE || masterReq.cmd == CMD_IO_WRITE;
        @(posedge core_clk);
        #1 masterGrant = 1'b1;
        @(posedge core_clk);
        #1 masterGrant = 1'b0;
        last = 1'b0;
        n = 0;
        k = 0;
        while (!last && n < 300) begin
          n++;
          if (wr) begin
            txReady = !(slow && n[0]);
          end else begin
            rxValid = !(slow && n[0]);
            // idle data is inverted so a stale word never looks valid
            rxData = rxValid ? rxBase + DATA_W'(k) : ~rxData;
          end
          @(negedge core_clk);
          if (wr && txValid && txReady) txq.push_back(txData);
          last = !master_end_request_n && (wr ? txValid && txReady : rxValid);
          k += int'(rxValid);
          @(posedge core_clk);
          #1;
        end
        txReady = 1'b0;
        rxValid = 1'b0;
        rxData = ~rxData;
        transactionEnd = 1'b1;
        @(posedge core_clk);
        #1 transactionEnd = 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ---- verilog/end_request_gen.sv ----
// Purpose: drives the active-low end-of-transaction request
// Assumes: one beat per completed data phase
// Notes: low while the last data phase of the transfer is pending
`default_nettype none
module end_request_gen #(
  parameter int COUNT_W = 8
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic start,
  input wire logic [COUNT_W-1:0] count,
  input wire logic beat,
  input wire logic abort,
  output logic master_end_request_n
);
  localparam logic [COUNT_W-1:0] LAST_PHASE = COUNT_W'(1);
  typedef struct packed {
    logic active;
    logic [COUNT_W-1:0] remaining;
  } gen_state_t;
  gen_state_t state;
  gen_state_t next_state;

  assign master_end_request_n =
    !(state.active && state.remaining == LAST_PHASE);

  always_comb begin
    next_state = state;
    if (start) begin
      next_state.active = count != '0;
      next_state.remaining = count;
    end else if (abort) begin
      next_state.active = 1'b0;
    end else if (beat && state.active) begin
      next_state.remaining = state.remaining - LAST_PHASE;
      next_state.active = state.remaining != LAST_PHASE;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state <= '0;
    end else if (ce) begin
      state <= next_state;
    end
  end
endmodule
`default_nettype wire

// ---- verilog/pci_master_dma_launcher.sv ----
// Purpose: DMA engine and local master behind a bus master function
// Assumes: register accesses and bus events are synchronous to core_clk
// Notes: at most one transaction per descriptor write; 1 KByte shared RAM
`default_nettype none
module pci_master_dma_launcher #(
  parameter int FIFO_WORDS = dma_pkg::FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic ce,
  input wire dma_pkg::reg_access_t regAccess,
  output logic [dma_pkg::DATA_W-1:0] regReadData,
  input wire dma_pkg::ram_port_t targetRam,
  output logic [dma_pkg::DATA_W-1:0] targetRamReadData,
  output dma_pkg::master_req_t masterReq,
  input wire logic masterGrant,
  input wire logic transactionEnd,
  output logic [dma_pkg::DATA_W-1:0] txData,
  output logic txValid,
  input wire logic txReady,
  input wire logic [dma_pkg::DATA_W-1:0] rxData,
  input wire logic rxValid,
  output logic master_end_request_n,
  output logic busy
);
  import dma_pkg::*;

  typedef struct packed {
    dma_state_t fsm;
    logic [DATA_W-1:0] system_address_reg;
    desc_t transfer_descriptor_reg;
    logic [DATA_W-1:0] ioReg;
    logic [RAM_ADDR_W-1:0] ramPtr;
    logic [RAM_ADDR_W-1:0] pfPtr;
    logic [COUNT_W-1:0] pfLeft;
    logic ioSent;
    logic [DATA_W-1:0] readData;
    master_req_t mreq;
  } state_t;
  localparam state_t STATE_RESET = '{
    fsm: ST_IDLE,
    system_address_reg: SYS_ADDR_RESET,
    transfer_descriptor_reg: DESC_RESET,
    ioReg: IO_REG_RESET,
    mreq: '0,
    default: '0
  };

  state_t state;
  state_t next_state;
  logic [DATA_W-1:0] ram [RAM_WORDS];
  desc_t wrDesc;
  desc_t readView;
  decode_t wrDecode;
  decode_t curDecode;
  logic trigger;
  logic [COUNT_W-1:0] genCount;
  logic fifoClear;
  logic fifoInReady;
  logic fifoOutValid;
  logic fifoOutReady;
  logic [DATA_W-1:0] fifoOutData;
  logic pfPush;
  logic ramWrite;
  logic txBeat;
  logic rxBeat;
  logic endAbort;

  // only the four control bits reach the decoder
  assign wrDesc = desc_t'(regAccess.data);
  assign wrDecode = decodeCtrl(wrDesc.ctrl);
  assign curDecode = decodeCtrl(state.transfer_descriptor_reg.ctrl);

  always_comb begin
    readView = state.transfer_descriptor_reg;
    readView.reserved = '0;
  end

  assign pfPush = state.pfLeft != '0;
  assign fifoOutReady = state.fsm == ST_WRITE && !curDecode.isIo && txReady;
  // whole words only: there is no byte-enable input at all
  assign txData = curDecode.isIo ? state.ioReg : fifoOutData;
  assign txValid = state.fsm == ST_WRITE &&
    (curDecode.isIo ? !state.ioSent : fifoOutValid);
  assign txBeat = txValid && txReady;
  assign rxBeat = state.fsm == ST_READ && rxValid;
  assign ramWrite = rxBeat && !curDecode.isIo;
  assign endAbort = transactionEnd && state.fsm != ST_IDLE;
  assign masterReq = state.mreq;
  assign regReadData = state.readData;
  assign busy = state.fsm != ST_IDLE;

  always_comb begin
    next_state = state;
    trigger = 1'b0;
    genCount = '0;
    fifoClear = 1'b0;
    if (regAccess.read) begin
      case (regAccess.addr)
        SYS_ADDR_OFFSET: next_state.readData = state.system_address_reg;
        DESC_OFFSET: next_state.readData = readView;
        default: next_state.readData = '0;
      endcase
    end
    if (regAccess.write && regAccess.addr == SYS_ADDR_OFFSET) begin
      next_state.system_address_reg = regAccess.data;
    end
    // a descriptor write while busy is dropped so the running transfer
    // never sees its fields change underneath it
    if (regAccess.write && regAccess.addr == DESC_OFFSET &&
        state.fsm == ST_IDLE) begin
      next_state.transfer_descriptor_reg = wrDesc;
      trigger = wrDecode.known &&
        (wrDecode.isIo || wrDesc.count != '0);
    end
    if (trigger) begin
      next_state.fsm = ST_REQ;
      next_state.mreq.req = 1'b1;
      next_state.mreq.cmd = wrDecode.cmd;
      next_state.mreq.addr = state.system_address_reg;
      next_state.mreq.wide = wrDecode.wide;
      next_state.pfPtr = wrDesc.localAddr;
      next_state.ramPtr = wrDesc.localAddr;
      next_state.pfLeft = (wrDecode.isWrite && !wrDecode.isIo) ?
        wrDesc.count : '0;
      next_state.ioSent = 1'b0;
      genCount = wrDecode.isIo ? COUNT_W'(1) : wrDesc.count;
    end
    // prefetch runs ahead of the data phases, from request onward
    if (pfPush && fifoInReady) begin
      next_state.pfPtr = state.pfPtr + 1'b1;
      next_state.pfLeft = state.pfLeft - 1'b1;
    end
    case (state.fsm)
      ST_IDLE: begin
      end
      ST_REQ: begin
        if (masterGrant) begin
          next_state.mreq.req = 1'b0;
          next_state.fsm = curDecode.isWrite ? ST_WRITE : ST_READ;
        end
      end
      ST_WRITE: begin
        if (curDecode.isIo && txBeat) begin
          next_state.ioSent = 1'b1;
        end
      end
      ST_READ: begin
        if (rxBeat && curDecode.isIo) begin
          next_state.ioReg = rxData;
        end else if (ramWrite) begin
          next_state.ramPtr = state.ramPtr + 1'b1;
        end
      end
      default: next_state.fsm = ST_IDLE;
    endcase
    if (endAbort) begin
      next_state.fsm = ST_IDLE;
      next_state.mreq.req = 1'b0;
      next_state.pfLeft = '0;
      fifoClear = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state <= STATE_RESET;
    end else if (ce) begin
      state <= next_state;
    end
  end

  // master write goes last so it wins a same-word collision
  always_ff @(posedge core_clk) begin
    if (ce) begin
      targetRamReadData <= ram[targetRam.addr];
      if (targetRam.write) begin
        ram[targetRam.addr] <= targetRam.data;
      end
      if (ramWrite) begin
        ram[state.ramPtr] <= rxData;
      end
    end
  end

  prefetch_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_WORDS)
  ) prefetchBuffer (
    .core_clk(core_clk),
    .srst(srst),
    .ce(ce),
    .clear(fifoClear),
    .inValid(pfPush),
    .inReady(fifoInReady),
    .inData(ram[state.pfPtr]),
    .outValid(fifoOutValid),
    .outReady(fifoOutReady),
    .outData(fifoOutData)
  );

  end_request_gen #(
    .COUNT_W(COUNT_W)
  ) endRequest (
    .core_clk(core_clk),
    .srst(srst),
    .ce(ce),
    .start(trigger),
    .count(genCount),
    .beat(txBeat || rxBeat),
    .abort(endAbort),
    .master_end_request_n(master_end_request_n)
  );

  // read data seen as a descriptor, for the reserved-field check
  desc_t readBack;
  assign readBack = desc_t'(regReadData);

  default clocking @(posedge core_clk); endclocking
  default disable iff (srst || !ce);

  a_start_request: assert property (
    trigger |=> masterReq.req && state.fsm == ST_REQ)
    else $error("descriptor write did not raise the request");
  a_address_phase: assert property (
    $rose(masterReq.req) |-> masterReq.addr == state.system_address_reg)
    else $error("request address differs from system address");
  a_command_decode: assert property (
    trigger && wrDesc.ctrl == CTRL_IO_RD |=> masterReq.cmd == CMD_IO_READ)
    else $error("I/O read code gave a wrong command");
  a_wide_select: assert property (
    trigger |=> masterReq.wide ==
      ($past(wrDesc.ctrl) == CTRL_MEM_RD64 ||
       $past(wrDesc.ctrl) == CTRL_MEM_WR64))
    else $error("64-bit selection wrong");
  a_io_single_word: assert property (
    txBeat && curDecode.isIo |=> !txValid [*2])
    else $error("I/O write presented a second word");
  a_io_end_request: assert property (
    state.fsm == ST_WRITE && curDecode.isIo && txValid |->
      !master_end_request_n)
    else $error("I/O transfer not flagged as last phase");
  a_back_to_idle: assert property (
    endAbort |=> state.fsm == ST_IDLE && !masterReq.req ##1
      (state.fsm == ST_IDLE || $past(trigger)))
    else $error("engine did not settle in idle after end");
  a_descriptor_fields: assert property (
    regAccess.write && regAccess.addr == DESC_OFFSET && !busy |=>
      state.transfer_descriptor_reg.count == $past(wrDesc.count) &&
      state.transfer_descriptor_reg.localAddr == $past(wrDesc.localAddr))
    else $error("descriptor fields not stored in place");
  a_address_readback: assert property (
    regAccess.read && regAccess.addr == SYS_ADDR_OFFSET |=>
      regReadData == $past(state.system_address_reg))
    else $error("system address read back wrong");
  a_prefetch_step: assert property (
    pfPush && fifoInReady && !trigger && !endAbort |=>
      state.pfLeft == $past(state.pfLeft) - 1'b1)
    else $error("prefetch count did not advance");
  a_ram_store: assert property (
    ramWrite && !(targetRam.write && targetRam.addr == state.ramPtr) |=>
      ram[$past(state.ramPtr)] == $past(rxData))
    else $error("read data not stored into RAM");

  // register window
  a_address_store: assert property (
    regAccess.write && regAccess.addr == SYS_ADDR_OFFSET |=>
      state.system_address_reg == $past(regAccess.data))
    else $error("system address write did not land");
  a_reserved_zero: assert property (
    regAccess.read && regAccess.addr == DESC_OFFSET |=>
      readBack.reserved == '0)
    else $error("reserved descriptor bits read back nonzero");
  a_window_unmapped: assert property (
    regAccess.read && regAccess.addr != SYS_ADDR_OFFSET &&
      regAccess.addr != DESC_OFFSET |=> regReadData == '0)
    else $error("unmapped offset read back nonzero");
  a_unknown_ignored: assert property (
    regAccess.write && regAccess.addr == DESC_OFFSET && !busy &&
      !wrDecode.known |=> !busy)
    else $error("unknown control code started a transfer");
  a_busy_descriptor: assert property (
    regAccess.write && regAccess.addr == DESC_OFFSET && busy |=>
      $stable(state.transfer_descriptor_reg))
    else $error("descriptor changed while a transfer ran");

  // start of a transfer
  a_local_start: assert property (
    trigger |=> state.ramPtr == $past(wrDesc.localAddr) &&
      state.pfPtr == $past(wrDesc.localAddr))
    else $error("local pointers not loaded from descriptor");
  a_count_load: assert property (
    trigger && wrDecode.isWrite && !wrDecode.isIo |=>
      state.pfLeft == $past(wrDesc.count))
    else $error("prefetch count not loaded from descriptor");
  a_io_count_ignored: assert property (
    trigger && wrDecode.isIo |=> !master_end_request_n &&
      state.pfLeft == '0)
    else $error("I/O transfer used the count field");
  a_request_held: assert property (
    state.fsm == ST_REQ && !masterGrant && !endAbort |=> masterReq.req)
    else $error("request dropped before grant");
  a_grant_taken: assert property (
    state.fsm == ST_REQ && masterGrant && !endAbort |=>
      !masterReq.req && state.fsm != ST_IDLE && state.fsm != ST_REQ)
    else $error("grant did not start the data phases");

  // data phases: the first write word must already wait in the buffer,
  // otherwise the bus would see an empty phase right after grant
  a_prefetch_ahead: assert property (
    state.fsm == ST_REQ && masterGrant && curDecode.isWrite &&
      !curDecode.isIo |=> fifoOutValid)
    else $error("no prefetched word at the first data phase");
  a_io_read_store: assert property (
    rxBeat && curDecode.isIo |=> state.ioReg == $past(rxData))
    else $error("I/O read word not stored in I/O register");
  a_end_last_beat: assert property (
    !master_end_request_n && (txBeat || rxBeat) |=> master_end_request_n)
    else $error("end request stayed low after the last phase");
  a_end_idle_high: assert property (
    !busy |-> master_end_request_n)
    else $error("end request low while idle");
  a_idle_quiet: assert property (
    state.fsm == ST_IDLE && !trigger |=> state.fsm == ST_IDLE &&
      !masterReq.req)
    else $error("engine left idle without a descriptor");

  c_memory_write: cover property (
    state.fsm == ST_WRITE && !curDecode.isIo && txBeat ##1 endAbort);
  c_memory_read: cover property (ramWrite ##1 ramWrite);
  c_io_write: cover property (txBeat && curDecode.isIo);
  c_fifo_full: cover property (pfPush && !fifoInReady);
  c_io_read: cover property (rxBeat && curDecode.isIo);
endmodule
`default_nettype wire

// ---- verilog/prefetch_fifo.sv ----
// Purpose: prefetch buffer between local RAM and outgoing bus data
// Assumes: DEPTH is a power of two
// Notes: clear drops all content in one cycle
`default_nettype none
module prefetch_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic clear,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_COUNT = (AW + 1)'(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [AW:0] count;
  } fifo_state_t;
  fifo_state_t state;
  fifo_state_t next_state;
  logic push;
  logic pop;

  assign inReady = state.count != FULL_COUNT;
  assign outValid = state.count != '0;
  assign outData = state.mem[state.rdPtr];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_comb begin
    next_state = state;
    if (push) begin
      next_state.mem[state.wrPtr] = inData;
      next_state.wrPtr = state.wrPtr + 1'b1;
    end
    if (pop) begin
      next_state.rdPtr = state.rdPtr + 1'b1;
    end
    next_state.count = state.count + (AW + 1)'(push) - (AW + 1)'(pop);
    if (clear) begin
      next_state.wrPtr = '0;
      next_state.rdPtr = '0;
      next_state.count = '0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state <= '0;
    end else if (ce) begin
      state <= next_state;
    end
  end
endmodule
`default_nettype wire
